// >>> watchdog_timer.sv
// Watchdog timer with sleep-aware clearing, four enable modes and a
// control register on a plain strobe port.
// Assumes sleep and wake signals come from logic on the same system clock.
//
// What this block does
// (RQ1) Entering Sleep clears the counter; an enabled watchdog then counts from zero.
// (RQ2) Leaving Sleep clears the counter; held clear until oscillator start-up finishes.
// (RQ3) Time-out during Sleep wakes the device instead of resetting it.
// (RQ4) A time-out drives the active-low timeout flag low; it drives the power-down flag low only in Sleep.
// (RQ5) Software mode with enable bit low holds the counter clear and disabled.
// (RQ6) Enable bit at bit 0 works only in software mode.
// (RQ7) Interrupt wake, clear instruction, oscillator failure and reset clear the counter.
// (RQ8) Clock switches and divider changes leave the counter alone.
// (RQ9) Period field bits 5..1 select prescale two to the (code plus five).
// (RQ10) Codes 10011 to 11111 give the minimum 1:32 interval.
// (RQ11) Every reset loads period code 01011, about two seconds.
// (RQ12) Counting uses the 31 kHz low-frequency oscillator tick.
// (RQ13) Control bits 7 and 6 read as zero.
// (RQ14) Mode 11 keeps the watchdog active always, Sleep included.
// (RQ15) Mode 10 is active awake, disabled in Sleep.
// (RQ16) Mode 00 clears and disables, ignoring the enable bit.
// (RQ17) Awake and active, a missed clear within the period resets the device.
// (RQ18) Count reaching the prescale gives one single time-out event.
`timescale 1ns/1ns
`include "wdog_params.svh"

module watchdog_timer
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire wdog_pkg::reg_req_type reg_req_i,
   output logic [7:0] reg_rdata_o,
   input wire wdog_pkg::mode_cfg_type wdog_mode_cfg_i,
   input wire logic sleep_i,
   input wire logic wake_irq_i,
   input wire logic wdog_clear_instr_i,
   input wire logic osc_fail_i,
   input wire logic osc_startup_timer_en_i,
   input wire logic osc_startup_done_i,
   output logic wdog_reset_o,
   output logic wdog_wake_o,
   output logic timeout_flag_n_o,
   output logic powerdown_flag_n_o,
   output logic wdog_active_o
);
   import wdog_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   // Prescale last count for a period code
   function automatic logic [`WDOG_CNT_W-1:0] period_last(input logic [4:0] code);
      logic [23:0] span;
      span = 24'h000000;
      // Reserved codes fall back to 1:32
      if (code > `PSEL_MAX_CODE)
      begin
         span = 24'h000001 << `PSEL_EXP_BASE;
      end
      else
      begin
         span = 24'h000001 << (code + 5'(`PSEL_EXP_BASE));
      end
      period_last = `WDOG_CNT_W'(span - 24'h000001);
   endfunction

   // Whether the watchdog runs in the given mode and power state
   function automatic logic mode_active(input mode_cfg_type mode, input logic sw_en,
                                        input logic asleep);
      case (mode)
         MODE_ON: mode_active = 1'b1;
         MODE_NO_SLEEP: mode_active = !asleep;
         MODE_SW: mode_active = sw_en;
         MODE_OFF: mode_active = 1'b0;
         default: mode_active = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Signals

   wdog_ctrl_type ctrl;
   pwr_state_type state;
   pwr_state_type next_state;
   logic [`WDOG_CNT_W-1:0] count;
   logic [`WDOG_CNT_W-1:0] last;
   logic lf_tick;
   logic active;
   logic asleep;
   logic sleep_enter;
   logic sleep_exit;
   logic cnt_clear;
   logic timeout;

   // Oscillator tick from the divider
   lf_tick_gen u_lf_tick
   (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .tick_o(lf_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Power state tracking

   assign asleep = (state == ST_SLEEP);
   assign sleep_enter = sleep_i && !asleep;
   assign sleep_exit = !sleep_i && asleep;

   // Next power state
   always_comb
   begin
      next_state = state;
      case (state)
         ST_AWAKE: next_state = sleep_i ? ST_SLEEP : ST_AWAKE;
         ST_SLEEP:
         begin
            // (RQ2) hold through start-up
            if (!sleep_i)
               next_state = osc_startup_timer_en_i ? ST_OST : ST_AWAKE;
         end
         ST_OST:
         begin
            if (sleep_i)
               next_state = ST_SLEEP;
            else if (osc_startup_done_i)
               next_state = ST_AWAKE;
         end
         default: next_state = ST_AWAKE;
      endcase
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         state <= ST_AWAKE;
      else
         state <= next_state;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter

   // (RQ5) (RQ6) (RQ14) (RQ15) (RQ16) mode table
   assign active = mode_active(wdog_mode_cfg_i, ctrl.sw_wdog_enable, asleep);
   // (RQ9) (RQ10) prescale select
   assign last = period_last(ctrl.wdog_period_sel);

   // (RQ18) single event at the selected count
   assign timeout = active && lf_tick && (state != ST_OST) && (count == last)
                    && !sleep_enter && !sleep_exit;

   // (RQ1) (RQ2) (RQ7) clear sources
   assign cnt_clear = !active || sleep_enter || sleep_exit || (state == ST_OST)
                      || wdog_clear_instr_i || osc_fail_i || (wake_irq_i && asleep)
                      || timeout;

   // (RQ8) (RQ12) Advances on oscillator ticks only; clock changes are no input
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         count <= '0;
      else if (cnt_clear)
         count <= '0;
      else if (lf_tick)
         count <= count + `WDOG_CNT_W'(1);
   end

   // (RQ3) (RQ17) Time-out resets awake, wakes in Sleep
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         wdog_reset_o <= 1'b0;
         wdog_wake_o <= 1'b0;
      end
      else
      begin
         wdog_reset_o <= timeout && !asleep;
         wdog_wake_o <= timeout && asleep;
      end
   end

   // (RQ4) Status flags; a time-out wins over a clear in the same cycle
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         timeout_flag_n_o <= 1'b1;
         powerdown_flag_n_o <= 1'b1;
      end
      else if (timeout)
      begin
         timeout_flag_n_o <= 1'b0;
         powerdown_flag_n_o <= asleep ? 1'b0 : powerdown_flag_n_o;
      end
      else if (wdog_clear_instr_i)
      begin
         timeout_flag_n_o <= 1'b1;
         powerdown_flag_n_o <= 1'b1;
      end
      else if (sleep_enter)
      begin
         timeout_flag_n_o <= 1'b1;
         powerdown_flag_n_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         wdog_active_o <= 1'b0;
      else
         wdog_active_o <= active;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register port

   // (RQ11) Control register, period code back to 01011 on reset
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         ctrl <= `CTRL_RESET;
      end
      else if (reg_req_i.wr && reg_req_i.addr == `OFS_WATCHDOG_CONTROL)
      begin
         ctrl.wdog_period_sel <= reg_req_i.wdata[`CTRL_PSEL_MSB:`CTRL_PSEL_LSB];
         ctrl.sw_wdog_enable <= reg_req_i.wdata[`CTRL_SW_EN_BIT];
      end
   end

   // (RQ13) Read data a cycle later; unmapped and unused bits are zero
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         reg_rdata_o <= 8'h00;
      end
      else if (reg_req_i.rd)
      begin
         reg_rdata_o <= 8'h00;
         if (reg_req_i.addr == `OFS_WATCHDOG_CONTROL)
            reg_rdata_o <= {2'h0, ctrl.wdog_period_sel, ctrl.sw_wdog_enable};
         else if (reg_req_i.addr == `OFS_WDOG_STATUS)
         begin
            reg_rdata_o[`STAT_PD_BIT] <= powerdown_flag_n_o;
            reg_rdata_o[`STAT_TO_BIT] <= timeout_flag_n_o;
            reg_rdata_o[`STAT_ACTIVE_BIT] <= active;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb_main @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   property p_sleep_entry_clear;
      sleep_enter |=> (count == '0);
   endproperty
   a_sleep_entry_clear: assert property (p_sleep_entry_clear) else $error("no clear on sleep"); // (RQ1)
   property p_ost_hold;
      (state == ST_OST) |=> (count == '0) && !wdog_reset_o;
   endproperty
   a_ost_hold: assert property (p_ost_hold) else $error("counter moved during start-up"); // (RQ2)
   property p_no_reset_in_sleep;
      (asleep && timeout) |=> wdog_wake_o && !wdog_reset_o;
   endproperty
   a_no_reset_in_sleep: assert property (p_no_reset_in_sleep) else $error("sleep reset"); // (RQ3)
   property p_flags_on_wake;
      wdog_wake_o |-> !timeout_flag_n_o && !powerdown_flag_n_o;
   endproperty
   a_flags_on_wake: assert property (p_flags_on_wake) else $error("flags not set on wake"); // (RQ4)
   property p_sw_off_clear;
      (wdog_mode_cfg_i == MODE_SW && !ctrl.sw_wdog_enable) |=> (count == '0);
   endproperty
   a_sw_off_clear: assert property (p_sw_off_clear) else $error("sw off but counting"); // (RQ5)
   property p_clear_instr;
      wdog_clear_instr_i |=> (count == '0) ##1 !wdog_reset_o;
   endproperty
   a_clear_instr: assert property (p_clear_instr) else $error("clear instr ignored"); // (RQ7)
   property p_fail_irq_clear;
      (osc_fail_i || (wake_irq_i && asleep)) |=> (count == '0);
   endproperty
   a_fail_irq_clear: assert property (p_fail_irq_clear) else $error("clear source ignored"); // (RQ7)
   property p_period_match;
      wdog_reset_o |-> ($past(count) == $past(last)) && $past(lf_tick);
   endproperty
   a_period_match: assert property (p_period_match) else $error("reset at wrong count"); // (RQ9)
   property p_reserved_min;
      (ctrl.wdog_period_sel > `PSEL_MAX_CODE) |-> (last == `WDOG_CNT_W'(31));
   endproperty
   a_reserved_min: assert property (p_reserved_min) else $error("reserved not 1:32"); // (RQ10)
   property p_reset_period;
      $past(rst_i) |-> (ctrl.wdog_period_sel == `PSEL_RESET) && !ctrl.sw_wdog_enable;
   endproperty
   a_reset_period: assert property (p_reset_period) else $error("bad reset period"); // (RQ11)
   property p_unused_zero;
      $past(reg_req_i.rd) |-> (reg_rdata_o[7:6] == 2'h0);
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("bits 7..6 not zero"); // (RQ13)
   property p_always_on;
      (wdog_mode_cfg_i == MODE_ON) |-> active;
   endproperty
   a_always_on: assert property (p_always_on) else $error("mode 11 inactive"); // (RQ14)
   property p_off_in_sleep;
      (wdog_mode_cfg_i == MODE_NO_SLEEP) |-> (active == !asleep);
   endproperty
   a_off_in_sleep: assert property (p_off_in_sleep) else $error("mode 10 wrong"); // (RQ15)
   property p_mode_off;
      (wdog_mode_cfg_i == MODE_OFF) |=> (count == '0) && !wdog_reset_o && !wdog_wake_o;
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("mode 00 not disabled"); // (RQ16)
   property p_reset_flags;
      wdog_reset_o |-> !timeout_flag_n_o ##1 (count == '0);
   endproperty
   a_reset_flags: assert property (p_reset_flags) else $error("reset without flag"); // (RQ17)

   c_awake_reset: cover property (wdog_reset_o);
   c_sleep_wake: cover property (wdog_wake_o);
   c_ost_done: cover property ((state == ST_OST) ##1 (state == ST_AWAKE));
   c_sw_mode_run: cover property ((wdog_mode_cfg_i == MODE_SW) && active && lf_tick);

endmodule

// >>> wdog_params.svh
// Constants for the watchdog timer: register offsets, field positions,
// reset values and timing counts. Assumes a 100 MHz system clock.
`ifndef WDOG_PARAMS_SVH
`define WDOG_PARAMS_SVH

// Register port
`define REG_ADDR_W 4
`define REG_DATA_W 8
`define OFS_WATCHDOG_CONTROL 4'h0
`define OFS_WDOG_STATUS 4'h1

// Control register fields
`define CTRL_SW_EN_BIT 0
`define CTRL_PSEL_LSB 1
`define CTRL_PSEL_MSB 5
`define CTRL_RESET 8'h16
`define PSEL_RESET 5'h0B

// Status register fields
`define STAT_PD_BIT 0
`define STAT_TO_BIT 1
`define STAT_ACTIVE_BIT 2

// Prescale: two to the power (code plus five), codes above 18 give 1:32
`define PSEL_EXP_BASE 5
`define PSEL_MAX_CODE 5'h12
`define WDOG_CNT_W 23

// Low-frequency oscillator tick derived from the system clock
`define CLK_PERIOD_NS 10
`define LF_OSC_PERIOD_NS 32258
`define LF_TICK_CYCLES (`LF_OSC_PERIOD_NS / `CLK_PERIOD_NS)
`define LF_DIV_W 12

`endif

// >>> wdog_pkg.sv
// Types shared by the watchdog timer files.
// Assumes wdog_params.svh is on the include path.
package wdog_pkg;

   // Mode configuration codes
   typedef enum logic [1:0]
   {
      MODE_OFF = 2'h0,
      MODE_SW = 2'h1,
      MODE_NO_SLEEP = 2'h2,
      MODE_ON = 2'h3
   } mode_cfg_type;

   // Power state of the device as the watchdog sees it
   typedef enum logic [2:0]
   {
      ST_AWAKE = 3'h1,
      ST_SLEEP = 3'h2,
      ST_OST = 3'h4
   } pwr_state_type;

   // Watchdog control register layout
   typedef struct packed
   {
      logic [1:0] unused;
      logic [4:0] wdog_period_sel;
      logic sw_wdog_enable;
   } wdog_ctrl_type;

   // Register port request
   typedef struct packed
   {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_type;

endpackage

// >>> lf_tick_gen.sv
// Divider that stands in for the low-frequency oscillator.
// Assumes one system clock; emits a one-cycle enable per oscillator period.
`timescale 1ns/1ns
`include "wdog_params.svh"

module lf_tick_gen
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   output logic tick_o
);
   import wdog_pkg::*;

   localparam logic [`LF_DIV_W-1:0] DIV_LAST = `LF_DIV_W'(`LF_TICK_CYCLES - 1);

   logic [`LF_DIV_W-1:0] div_cnt;

   // Free-running divider, never gated by the system clock setup
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         div_cnt <= '0;
      end
      else if (div_cnt == DIV_LAST)
      begin
         div_cnt <= '0;
      end
      else
      begin
         div_cnt <= div_cnt + `LF_DIV_W'(1);
      end
   end

   // Registered so the tick is one clean cycle
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         tick_o <= 1'b0;
      end
      else
      begin
         tick_o <= (div_cnt == DIV_LAST);
      end
   end

   default clocking cb_tick @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   property p_tick_single;
      tick_o |=> !tick_o;
   endproperty
   a_tick_single: assert property (p_tick_single) else $error("tick lasted two cycles"); // (RQ12)

endmodule

// >>> watchdog_timer_tb.sv
// Self-checking bench for the watchdog timer: register port, enable modes,
// sleep handling, flags and time-out windows.
// Assumes wdog_params.svh and wdog_pkg are compiled before this file.
`timescale 1ns/1ns
`include "wdog_params.svh"

module watchdog_timer_tb;
   import wdog_pkg::*;

   // One oscillator tick in system clocks; the time-out windows allow one tick of slack
   localparam int TICK = `LF_TICK_CYCLES;
   localparam int LIMIT = 300000;

   logic clk_sys_i;
   logic rst_i;
   reg_req_type reg_req;
   mode_cfg_type mode;
   logic sleep;
   logic wake_irq;
   logic clr;
   logic osc_fail;
   logic ost_en;
   logic ost_done;
   logic [7:0] rdata;
   logic wd_reset;
   logic wd_wake;
   logic to_n;
   logic pd_n;
   logic active;
   int failures;
   int tests_run;
   int cycles = 0;
   logic [7:0] d;
   logic [7:0] v;
   logic [4:0] code;
   int n;
   bit other;

   watchdog_timer u_watchdog_timer
   (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .reg_req_i(reg_req),
      .reg_rdata_o(rdata),
      .wdog_mode_cfg_i(mode),
      .sleep_i(sleep),
      .wake_irq_i(wake_irq),
      .wdog_clear_instr_i(clr),
      .osc_fail_i(osc_fail),
      .osc_startup_timer_en_i(ost_en),
      .osc_startup_done_i(ost_done),
      .wdog_reset_o(wd_reset),
      .wdog_wake_o(wd_wake),
      .timeout_flag_n_o(to_n),
      .powerdown_flag_n_o(pd_n),
      .wdog_active_o(active)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial
   begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // Long time-outs mean a stuck counter; cut the run short
   always @(posedge clk_sys_i)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         failures = failures + 1;
         $display("ERROR at %0t: run did not finish", $time);
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Expected enable state from mode, software bit and power state
   function automatic logic exp_active(input int m, input logic sw, input logic asleep);
      case (m)
         3: return 1'b1;
         2: return !asleep;
         1: return sw;
         default: return 1'b0;
      endcase
   endfunction

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] w);
      @(posedge clk_sys_i);
      reg_req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys_i);
      reg_req.wr <= 1'b0;
   endtask

   // Read data stand from the cycle after the strobe until the next read strobe
   task automatic reg_rd(input logic [3:0] a, output logic [7:0] r);
      @(posedge clk_sys_i);
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys_i);
      reg_req.rd <= 1'b0;
      #1;
      r = rdata;
   endtask

   // Counts cycles until the wanted pulse, noting the other one if it shows
   task automatic wait_pulse(input bit want_wake, output int cnt, output bit oth);
      cnt = 0;
      oth = 0;
      while (cnt < 40 * TICK)
      begin
         @(posedge clk_sys_i);
         #1;
         cnt = cnt + 1;
         if ((want_wake ? wd_wake : wd_reset) === 1'b1)
            break;
         if ((want_wake ? wd_reset : wd_wake) === 1'b1)
            oth = 1;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      rst_i = 1'b1;
      reg_req = '0;
      mode = MODE_OFF;
      sleep = 1'b0;
      wake_irq = 1'b0;
      clr = 1'b0;
      osc_fail = 1'b0;
      ost_en = 1'b0;
      ost_done = 1'b0;
      failures = 0;
      tests_run = 0;
      void'($urandom(32'h26b9d313));
      repeat (4) @(posedge clk_sys_i);
      rst_i <= 1'b0;

      // Reset contents and idle flags
      reg_rd(`OFS_WATCHDOG_CONTROL, d);
      check(d, {2'b00, `PSEL_RESET, 1'b0});
      reg_rd(`OFS_WDOG_STATUS, d);
      check(d, 8'h03);

      // Random writes; top bits read zero, other addresses refuse writes
      repeat (8)
      begin
         v = 8'($urandom);
         reg_wr(`OFS_WATCHDOG_CONTROL, v);
         reg_wr(`OFS_WDOG_STATUS, ~v);
         reg_rd(`OFS_WATCHDOG_CONTROL, d);
         check(d, v & 8'h3F);
         reg_rd(4'h7, d);
         check(d, 8'h00);
      end

      // Every mode against software bit and power state
      for (int m = 0; m < 4; m++)
         for (int sw = 0; sw < 2; sw++)
            for (int s = 0; s < 2; s++)
            begin
               mode <= mode_cfg_type'(m[1:0]);
               reg_wr(`OFS_WATCHDOG_CONTROL, {7'h00, sw[0]});
               sleep <= s[0];
               repeat (4) @(posedge clk_sys_i);
               #1;
               check({7'h00, active}, {7'h00, exp_active(m, sw[0], s[0])});
               if (s == 1)
                  check({6'h00, to_n, pd_n}, 8'h02);
               sleep <= 1'b0;
               repeat (4) @(posedge clk_sys_i);
            end

      // Awake time-out with a reserved code, after start-up hold and a late clear
      mode <= MODE_ON;
      code = 5'(19 + $urandom % 13);
      reg_wr(`OFS_WATCHDOG_CONTROL, {2'b00, code, 1'b0});
      ost_en <= 1'b1;
      sleep <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      sleep <= 1'b0;
      repeat (2 * TICK) @(posedge clk_sys_i);
      ost_done <= 1'b1;
      @(posedge clk_sys_i);
      ost_done <= 1'b0;
      ost_en <= 1'b0;
      repeat (TICK) @(posedge clk_sys_i);
      clr <= 1'b1;
      @(posedge clk_sys_i);
      clr <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #1;
      check({6'h00, to_n, pd_n}, 8'h03);
      wait_pulse(1'b0, n, other);
      // Counted from two cycles after the clear took effect
      check({7'h00, n + 2 >= 31 * TICK && n + 2 <= 33 * TICK}, 8'h01);
      check({7'h00, other}, 8'h00);
      check({6'h00, to_n, pd_n}, 8'h01);
      @(posedge clk_sys_i);
      #1;
      check({7'h00, wd_reset}, 8'h00);

      // Sleep time-out wakes instead of resetting
      reg_wr(`OFS_WATCHDOG_CONTROL, 8'h00);
      sleep <= 1'b1;
      wait_pulse(1'b1, n, other);
      check({7'h00, n >= 31 * TICK && n <= 33 * TICK}, 8'h01);
      check({7'h00, other}, 8'h00);
      check({6'h00, to_n, pd_n}, 8'h00);

      // Interrupt wake and oscillator failure clear a running count
      repeat (2 * TICK) @(posedge clk_sys_i);
      wake_irq <= 1'b1;
      @(posedge clk_sys_i);
      wake_irq <= 1'b0;
      repeat (2 * TICK) @(posedge clk_sys_i);
      osc_fail <= 1'b1;
      @(posedge clk_sys_i);
      osc_fail <= 1'b0;
      sleep <= 1'b0;
      repeat (4) @(posedge clk_sys_i);

      // Mid-run reset restores the reset period
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      reg_rd(`OFS_WATCHDOG_CONTROL, d);
      check(d, {2'b00, `PSEL_RESET, 1'b0});
      give_verdict();
   end

endmodule
